// >>> rtl/msw_params.svh
// constants for the modem sleep, wake and reset block
`ifndef MSW_PARAMS_SVH
`define MSW_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define MSW_CLK_HZ 10000000
`define MSW_READY_MS 25
`define MSW_READY_CYC ((`MSW_CLK_HZ / 1000) * `MSW_READY_MS)
`define MSW_XTAL_KHZ 28224
`define MSW_TICK_DIV 10000
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define MSW_IDLE_W 8
`define MSW_IDLE_RST 8'h0A
`define MSW_SRAM_AW 6
`define MSW_SRAM_DW 8
`define MSW_ZERO8 8'h00
`endif

// >>> rtl/msw_pkg.sv
// types for the modem sleep, wake and reset block
`default_nettype none
package msw_pkg;
   typedef enum logic [1:0] {ST_RESET, ST_CLEAR, ST_AWAKE, ST_SLEEP} msw_state_e;
   // wake and activity causes travel together
   typedef struct packed
   {
      logic ring;
      logic host_write;
      logic serial_char;
      logic line_active;
   } msw_events_s;
endpackage
`default_nettype wire

// >>> rtl/msw_sram.sv
// small on-chip scratch memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "msw_params.svh"
module msw_sram #(
   parameter int AW = `MSW_SRAM_AW,
   parameter int DW = `MSW_SRAM_DW
) (
   // clock
   input wire logic clk,
   // port
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule // msw_sram
`default_nettype wire

// >>> rtl/msw_top.sv
// sleep entry, wake-up, reset release and speaker slicer for the modem core
//
// Function
// - sleep is entered only with no line connection and host idle for the programmed time.
// - while asleep circuits_enable is low; the clock logic, synchronisers and speaker flop keep running, so wake is immediate.
// - a detected ring wakes the device.
// - in parallel host mode any host write wakes the device.
// - in serial host mode a received terminal character wakes the device.
// - active-low reset reinitialises all logic except the pin synchronisers, tick divider and speaker and crystal flops, and clears the internal memory.
// - the device stays in reset while reset is low and leaves it on the rising edge.
// - ready is signalled 25 ms after the reset rising edge, not before.
// - the speaker output is the received line signal sliced to a logic level.
// - all timing derives from the 10 MHz clk; the 28.224 MHz crystal level only passes through the synchronisers and a registered inverter.
`timescale 1ns/1ps
`default_nettype none
`include "msw_params.svh"
module msw_top #(
   parameter int READY_CYC = `MSW_READY_CYC,
   parameter int TICK_DIV = `MSW_TICK_DIV
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic reset_n_pin,
   // crystal
   input wire logic crystal_in,
   output logic crystal_out,
   // configuration and events
   input wire logic parallel_mode,
   input wire logic [`MSW_IDLE_W-1:0] sleep_idle_time_register,
   input wire logic line_connected,
   input wire msw_pkg::msw_events_s events,
   input wire logic rx_line_level,
   // status
   output logic ready,
   output logic asleep,
   output logic circuits_enable,
   output logic call_progress_speaker_out
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // the crystal, reset, line-level and ring pins pass two flops before any use
   // the crystal level is only sampled here; the real oscillator pad sits outside this clock
   logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
   always_comb
   begin
      sync1_d = {crystal_in, reset_n_pin, rx_line_level, events.ring};
      sync2_d = sync1_q;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end
   logic xtal_s, res_n_s, rx_s, ring_s;
   assign xtal_s = sync2_q[3];
   assign res_n_s = sync2_q[2];
   assign rx_s = sync2_q[1];
   assign ring_s = sync2_q[0];

   // ----------------------------------------
   // state machine and counters
   // ----------------------------------------
   msw_pkg::msw_state_e state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic [31:0] div_q, div_d;
   logic [`MSW_IDLE_W-1:0] idle_q, idle_d;
   logic [`MSW_SRAM_AW-1:0] clr_q, clr_d;
   logic ready_q, ready_d, spk_q, spk_d, xo_q, xo_d;
   logic activity, wake, tick;

   assign activity = events.line_active | events.host_write | events.serial_char | ring_s;
   assign wake = ring_s
      | (parallel_mode & events.host_write)
      | (~parallel_mode & events.serial_char);
   assign tick = (div_q == 32'(TICK_DIV - 1));

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      div_d = tick ? 32'h0 : div_q + 32'h1;
      idle_d = idle_q;
      clr_d = clr_q;
      ready_d = ready_q;
      spk_d = rx_s;
      xo_d = ~xtal_s; // inverting crystal amplifier stage
      case (state_q)
         msw_pkg::ST_RESET:
         begin
            // held here while the pin is low
            ready_d = 1'b0;
            cnt_d = 32'h0;
            clr_d = '0;
            if (res_n_s)
            begin
               state_d = msw_pkg::ST_CLEAR;
            end
         end
         msw_pkg::ST_CLEAR:
         begin
            // wipe memory one word per cycle after release
            clr_d = clr_q + 1'b1;
            cnt_d = cnt_q + 32'h1;
            if (&clr_q)
            begin
               state_d = msw_pkg::ST_AWAKE;
            end
         end
         msw_pkg::ST_AWAKE:
         begin
            if (!ready_q)
            begin
               cnt_d = cnt_q + 32'h1;
               if (cnt_q >= 32'(READY_CYC - 1))
               begin
                  ready_d = 1'b1;
               end
            end
            if (activity || line_connected)
            begin
               idle_d = '0;
            end
            else if (tick && idle_q != sleep_idle_time_register)
            begin
               idle_d = idle_q + 1'b1;
            end
            if (ready_q && !line_connected && !activity
               && idle_q == sleep_idle_time_register)
            begin
               state_d = msw_pkg::ST_SLEEP;
            end
         end
         msw_pkg::ST_SLEEP:
         begin
            if (wake)
            begin
               idle_d = '0;
               state_d = msw_pkg::ST_AWAKE;
            end
         end
         default:
         begin
            state_d = msw_pkg::ST_RESET;
         end
      endcase
      if (!res_n_s)
      begin
         state_d = msw_pkg::ST_RESET;
         ready_d = 1'b0;
         idle_d = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= msw_pkg::ST_RESET;
         cnt_q <= 32'h0;
         div_q <= 32'h0;
         idle_q <= '0;
         clr_q <= '0;
         ready_q <= 1'b0;
         spk_q <= 1'b0;
         xo_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         div_q <= div_d;
         idle_q <= idle_d;
         clr_q <= clr_d;
         ready_q <= ready_d;
         spk_q <= spk_d;
         xo_q <= xo_d;
      end
   end

   // ----------------------------------------
   // internal memory, cleared after reset
   // ----------------------------------------
   logic [`MSW_SRAM_DW-1:0] sram_rdata;
   msw_sram #(.AW(`MSW_SRAM_AW), .DW(`MSW_SRAM_DW)) u_sram (
      .clk(clk),
      .we(state_q == msw_pkg::ST_CLEAR),
      .addr(clr_q),
      .wdata(`MSW_ZERO8),
      .rdata(sram_rdata)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // gating is a level only; the clock tree itself keeps running
   logic asleep_q, asleep_d, en_q, en_d;
   // taken from the next state so the flags line up with state_q
   always_comb
   begin
      asleep_d = (state_d == msw_pkg::ST_SLEEP);
      en_d = (state_d == msw_pkg::ST_AWAKE);
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         asleep_q <= 1'b0;
         en_q <= 1'b0;
      end
      else
      begin
         asleep_q <= asleep_d;
         en_q <= en_d;
      end
   end
   assign asleep = asleep_q;
   assign circuits_enable = en_q;
   assign ready = ready_q;
   assign call_progress_speaker_out = spk_q;
   assign crystal_out = xo_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_sleep_entry: assert property (@(posedge clk) disable iff (rst)
      (state_q != msw_pkg::ST_SLEEP && state_d == msw_pkg::ST_SLEEP)
      |-> (!line_connected && idle_q == sleep_idle_time_register))
      else $error("sleep entered while busy");
   chk_sleep_gate: assert property (@(posedge clk) disable iff (rst)
      asleep |-> !circuits_enable)
      else $error("circuits on while asleep");
   chk_ring_wake: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_SLEEP && ring_s && res_n_s) |=> state_q == msw_pkg::ST_AWAKE)
      else $error("ring did not wake");
   chk_host_wake: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_SLEEP && parallel_mode && events.host_write && res_n_s)
      |=> !asleep)
      else $error("host write did not wake");
   chk_char_wake: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_SLEEP && !parallel_mode && events.serial_char && res_n_s)
      |=> state_q == msw_pkg::ST_AWAKE)
      else $error("character did not wake");
   chk_reset_hold: assert property (@(posedge clk) disable iff (rst)
      !res_n_s |=> (state_q == msw_pkg::ST_RESET && !ready))
      else $error("not held in reset");
   chk_sram_clear: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_RESET && res_n_s) |=> state_q == msw_pkg::ST_CLEAR)
      else $error("memory clear skipped");
   chk_ready_time: assert property (@(posedge clk) disable iff (rst)
      $rose(ready) |-> cnt_q == 32'(READY_CYC))
      else $error("ready at wrong time");
   chk_idle_clear: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_SLEEP && state_d == msw_pkg::ST_AWAKE) |=> idle_q == '0)
      else $error("idle timer not cleared");
   chk_speaker: assert property (@(posedge clk) disable iff (rst)
      ##1 call_progress_speaker_out == $past(rx_s))
      else $error("speaker not sliced line");

   // ----------------------------------------
   // clock, sleep, wake, memory, idle and ready checks
   // ----------------------------------------
   // only word 0 is read back; the sweep check covers the other addresses
   chk_clock_alive: assert property (@(posedge clk) disable iff (rst)
      asleep |=> crystal_out == ~$past(xtal_s))
      else $error("clock stage stopped in sleep");
   chk_sleep_ready: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_AWAKE && state_d == msw_pkg::ST_SLEEP)
      |-> (ready && !activity))
      else $error("sleep entered before ready");
   chk_idle_restart: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_AWAKE && res_n_s && (activity || line_connected))
      |=> idle_q == '0)
      else $error("idle timer kept counting");
   chk_wrong_mode: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_SLEEP && !ring_s && res_n_s
      && !(parallel_mode ? events.host_write : events.serial_char))
      |=> state_q == msw_pkg::ST_SLEEP)
      else $error("woke without a cause");
   chk_clear_span: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_CLEAR && !(&clr_q) && res_n_s)
      |=> (state_q == msw_pkg::ST_CLEAR && clr_q == $past(clr_q) + 1'b1))
      else $error("memory clear cut short");
   chk_sram_zero: assert property (@(posedge clk) disable iff (rst)
      (state_q == msw_pkg::ST_AWAKE && $past(state_q) == msw_pkg::ST_AWAKE)
      |-> sram_rdata == '0)
      else $error("memory word not cleared");
   chk_ready_early: assert property (@(posedge clk) disable iff (rst)
      (!ready && cnt_q < 32'(READY_CYC - 1)) |=> !ready)
      else $error("ready raised early");
endmodule // msw_top
`default_nettype wire

// >>> sim/msw_host_model.sv
// host model that drives the modem reset pin
`timescale 1ns/1ps
`default_nettype none
module msw_host_model #(
   parameter int HOLD_CYC = 150
) (
   // clock
   input wire logic clk,
   // request a reset pulse
   input wire logic req,
   // reset pin, active low
   output logic reset_n_pin
);
   int cnt_q = HOLD_CYC;
   // ----------------------------------------
   // reset hold, scaled down so the run stays short
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (req)
         cnt_q <= HOLD_CYC;
      else if (cnt_q > 0)
         cnt_q <= cnt_q - 1;
   end
   assign reset_n_pin = (cnt_q == 0);
endmodule // msw_host_model
`default_nettype wire

// >>> sim/msw_top_tb.sv
// self-checking bench for the modem sleep, wake and reset block
`timescale 1ns/1ps
`default_nettype none
`include "msw_params.svh"
module msw_top_tb;
   localparam int READY_CYC = 200;
   localparam int TICK_DIV = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic reset_n_pin;
   logic crystal_in = 1'b0;
   logic crystal_out;
   logic parallel_mode = 1'b1;
   logic [`MSW_IDLE_W-1:0] idle_reg = 8'h03;
   logic line_connected = 1'b1;
   msw_pkg::msw_events_s events = '0;
   logic rx_line_level = 1'b0;
   logic ready, asleep, circuits_enable, spk;
   int fail_count = 0;
   int checks = 0;
   always #50 clk = ~clk;
   msw_host_model host (.clk(clk), .req(req), .reset_n_pin(reset_n_pin));
   msw_top #(.READY_CYC(READY_CYC), .TICK_DIV(TICK_DIV)) uut (
      .clk(clk), .rst(rst), .reset_n_pin(reset_n_pin),
      .crystal_in(crystal_in), .crystal_out(crystal_out),
      .parallel_mode(parallel_mode), .sleep_idle_time_register(idle_reg),
      .line_connected(line_connected), .events(events), .rx_line_level(rx_line_level),
      .ready(ready), .asleep(asleep), .circuits_enable(circuits_enable),
      .call_progress_speaker_out(spk));
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task check(input string what, input logic seen, input logic exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // samples at falling edges so the design's updates have landed
   task wait_for(input int which, input logic v, input int lim, input string what);
      logic cur;
      int i;
      cur = 1'bx;
      for (i = 0; i < lim; i++)
      begin
         @(negedge clk);
         cur = (which == 0) ? ready : ((which == 1) ? asleep : reset_n_pin);
         if (cur === v)
            break;
      end
      check(what, cur, v);
      if (cur !== v)
         report_and_stop;
   endtask
   task pulse(input logic [3:0] m);
      @(posedge clk);
      events <= msw_pkg::msw_events_s'(m);
      @(posedge clk);
      events <= '0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task test_reset;
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      cyc(10);
      check("ready in reset", ready, 1'b0);
      check("asleep in reset", asleep, 1'b0);
      check("enable in reset", circuits_enable, 1'b0);
      wait_for(2, 1'b1, 400, "pin release");
      cyc(READY_CYC - 10);
      check("ready early", ready, 1'b0);
      wait_for(0, 1'b1, 30, "ready");
      check("awake after reset", circuits_enable, 1'b1);
      $display("test_reset done");
   endtask
   task test_paths;
      logic [7:0] pat;
      int i;
      pat = 8'h55;
      for (i = 0; i < 8; i++)
      begin
         @(posedge clk);
         rx_line_level <= pat[i];
         crystal_in <= pat[i];
         cyc(2);
         check("speaker old", spk, ~pat[i]);
         cyc(2);
         check("speaker new", spk, pat[i]);
         check("crystal out", crystal_out, ~pat[i]);
      end
      $display("test_paths done");
   endtask
   task test_sleep_entry;
      cyc(60);
      check("no sleep on line", asleep, 1'b0);
      @(posedge clk);
      line_connected <= 1'b0;
      repeat (8)
      begin
         pulse(4'h1);
         cyc(4);
      end
      check("no sleep with activity", asleep, 1'b0);
      cyc(TICK_DIV - 2);
      check("no sleep before idle", asleep, 1'b0);
      wait_for(1, 1'b1, 40, "sleep entry");
      check("circuits off asleep", circuits_enable, 1'b0);
      $display("test_sleep_entry done");
   endtask
   task test_wake;
      logic [3:0] cause [6];
      logic mode [6];
      logic wakes [6];
      int i;
      cause = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h8};
      mode = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      wakes = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (i = 0; i < 6; i++)
      begin
         @(posedge clk);
         parallel_mode <= mode[i];
         wait_for(1, 1'b1, 60, "asleep again");
         pulse(cause[i]);
         cyc(8);
         check("woken", ~asleep, wakes[i]);
         check("circuits on", circuits_enable, wakes[i]);
      end
      $display("test_wake done");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      test_reset;
      test_paths;
      test_sleep_entry;
      test_wake;
      test_reset;
      report_and_stop;
   end
endmodule // msw_top_tb
`default_nettype wire
